// ===== dram_port_a_map.vh
// constants for the dram port a access handshake block
`ifndef DRAM_PORT_A_MAP_VH
`define DRAM_PORT_A_MAP_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define REG_ADDR_W 8
`define OFS_CONFIG 8'h00
`define OFS_STATUS 8'h04
`define OFS_ACC_COUNT 8'h08

// ----------------------------------------
// config register fields and reset value
// ----------------------------------------
`define CFG_W 8
`define CFG_RST 8'h14
`define CFG_MODE_BIT 0
`define CFG_ACK_STYLE_BIT 1
`define CFG_LATCH_BIT 2
`define CFG_WAIT_LSB 4
`define CFG_WAIT_MSB 7
`define WAIT_W 4

// ----------------------------------------
// status register fields
// ----------------------------------------
`define STAT_PEND_BIT 0
`define STAT_ACTIVE_BIT 1
`define STAT_READY_BIT 2
`define STAT_HOLD_BIT 3
`define STAT_WAIT_LSB 8

// ----------------------------------------
// access counter
// ----------------------------------------
`define CNT_W 16
`define CNT_RST 16'h0000
`define CNT_ONE 16'h0001

`endif

// ===== strobe_addr_capture.v
// address capture on the low-going edge of the shared strobe
`timescale 1ns/100ps
module strobe_addr_capture #(
    parameter BANK_W = 2,
    parameter ROW_W = 11,
    parameter COL_W = 11
) (
    // clock and reset
    input wire i_mclk,
    input wire i_rst,
    // strobe and control
    input wire i_strobe_pin,
    input wire i_latch_en,
    // live address
    input wire [BANK_W-1:0] i_bank,
    input wire [ROW_W-1:0] i_row,
    input wire [COL_W-1:0] i_col,
    // captured address
    output reg [BANK_W-1:0] o_bank,
    output reg [ROW_W-1:0] o_row,
    output reg [COL_W-1:0] o_col
);

reg strobe_prev_ff;
wire fall_edge;

// pin samples are synchronous to the clock, so no synchroniser here
assign fall_edge = strobe_prev_ff & ~i_strobe_pin;

always @(posedge i_mclk) begin
    if (i_rst) begin
        strobe_prev_ff <= 1'b0;
        o_bank <= {BANK_W{1'b0}};
        o_row <= {ROW_W{1'b0}};
        o_col <= {COL_W{1'b0}};
    end else begin
        strobe_prev_ff <= i_strobe_pin;
        // without latching the address simply flows through one flop
        if (fall_edge | ~i_latch_en) begin // RL5
            o_bank <= i_bank;
            o_row <= i_row;
            o_col <= i_col;
        end
    end
end

endmodule

// ===== wait_state_counter.v
// wait-state delay counter with dynamic extension
`timescale 1ns/100ps
module wait_state_counter #(
    parameter WAIT_W = 4
) (
    // clock and reset
    input wire i_mclk,
    input wire i_rst,
    // control
    input wire i_load,
    input wire [WAIT_W-1:0] i_load_val,
    input wire i_run,
    input wire i_extend,
    // status
    output reg o_done,
    output reg [WAIT_W-1:0] o_count
);

always @(posedge i_mclk) begin
    if (i_rst) begin
        o_count <= {WAIT_W{1'b0}};
        o_done <= 1'b0;
    end else if (i_load) begin
        o_count <= i_load_val;
        o_done <= 1'b0;
    end else if (i_run & ~i_extend) begin // RL13
        if (o_count != {WAIT_W{1'b0}}) begin // RL12
            o_count <= o_count - {{(WAIT_W-1){1'b0}}, 1'b1};
        end else begin
            // sticky so a late extend cannot pull ready back
            o_done <= 1'b1;
        end
    end
end

endmodule

// ===== dram_port_a_access_handshake.v
// port a access front end: strobe, select, request and wait/ack logic
//
// Overview of operation
// (RL1) mode 0: strobe high with select low sets the access-pending latch
// (RL2) pending latch set: access starts at the next free rising clock edge
// (RL3) mode 1: strobe low with select, nothing busy: row strobe asserts at once
// (RL4) mode 1 while busy: row strobe asserts at first edge after busy ends
// (RL5) with latching on, bank/row/column captured on strobe low-going edge
// (RL6) no access starts while the port select is negated
// (RL7) mode 0: requester asserts request after first edge following strobe
// (RL8) negating the access request negates the row strobe of the access
// (RL9) mode 1: requester asserts request before releasing the address strobe
// (RL10) ack style bit clear: output is active-low wait while not ready
// (RL11) ack style bit set: output low once access done, high while waiting
// (RL12) ready indication delayed by the programmed number of clock edges
// (RL13) extend input held during an access adds further clock edges
// (RL14) row strobes latch the row address shown on the address outputs
// (RL15) access end on request negation clears pending latch; new strobe needed
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "dram_port_a_map.vh"
module dram_port_a_access_handshake #(
    parameter BANK_W = 2,
    parameter ROW_W = 11,
    parameter COL_W = 11
) (
    // clock and reset
    input wire i_mclk,
    input wire i_rst,
    // register port
    input wire [`REG_ADDR_W-1:0] i_reg_addr,
    input wire [31:0] i_reg_wdata,
    input wire i_reg_wr,
    input wire i_reg_rd,
    output wire [31:0] o_reg_rdata,
    // access port
    input wire i_addr_strobe_in,
    input wire i_port_select_n,
    input wire i_access_request_in_n,
    input wire i_extend_delay_in,
    input wire i_event_busy,
    // live address
    input wire [BANK_W-1:0] i_bank_addr,
    input wire [ROW_W-1:0] i_row_addr,
    input wire [COL_W-1:0] i_col_addr,
    // dram side
    output wire [(1<<BANK_W)-1:0] o_row_strobe_n,
    output wire [ROW_W-1:0] o_mux_addr,
    output wire [COL_W-1:0] o_col_addr,
    output wire [BANK_W-1:0] o_bank_addr,
    // processor side
    output wire o_transfer_ack_out,
    output wire o_access_active
);

// ----------------------------------------
// states
// ----------------------------------------
localparam ST_IDLE = 4'b0001;
localparam ST_PEND = 4'b0010;
localparam ST_HOLD = 4'b0100;
localparam ST_ACC = 4'b1000;

localparam NB = 1 << BANK_W;

// ----------------------------------------
// functions
// ----------------------------------------
function [NB-1:0] bank_onehot;
    input [BANK_W-1:0] bank;
    integer k;
    begin
        bank_onehot = {NB{1'b0}};
        for (k = 0; k < NB; k = k + 1) begin
            if (bank == k[BANK_W-1:0]) begin
                bank_onehot[k] = 1'b1;
            end
        end
    end
endfunction

// strobe polarity follows the mode: high latch enable or low address strobe
function strobe_on;
    input mode;
    input pin;
    begin
        strobe_on = mode ? ~pin : pin;
    end
endfunction

// write decode shared by every writable register
function wr_hit;
    input wr;
    input [`REG_ADDR_W-1:0] addr;
    input [`REG_ADDR_W-1:0] ofs;
    begin
        wr_hit = wr & (addr == ofs);
    end
endfunction

// ----------------------------------------
// declarations
// ----------------------------------------
reg [`CFG_W-1:0] cfg_ff;
reg [`CFG_W-1:0] nxt_cfg;
reg [3:0] state_ff;
reg [3:0] nxt_state;
reg pending_ff;
reg nxt_pending;
reg req_seen_ff;
reg nxt_req_seen;
reg ras_ff;
reg nxt_ras;
// cleared by each start, set again once the strobe is seen released
reg strobe_armed_ff;
reg nxt_armed;
reg [`CNT_W-1:0] acc_cnt_ff;
reg [`CNT_W-1:0] nxt_acc_cnt;
reg [31:0] rdata_ff;
reg [31:0] nxt_rdata;

wire mode;
wire ack_style;
wire latch_en;
wire [`WAIT_W-1:0] wait_cfg;
wire sel;
wire req;
wire strobe;
wire start_now;
wire acc_end;
wire enter_acc;
wire wait_done;
wire [`WAIT_W-1:0] wait_cnt;
wire ready;
wire not_ready;
wire [BANK_W-1:0] lat_bank;
wire [ROW_W-1:0] lat_row;
wire [COL_W-1:0] lat_col;
reg [31:0] status_word;

assign mode = cfg_ff[`CFG_MODE_BIT];
assign ack_style = cfg_ff[`CFG_ACK_STYLE_BIT];
assign latch_en = cfg_ff[`CFG_LATCH_BIT];
assign wait_cfg = cfg_ff[`CFG_WAIT_MSB:`CFG_WAIT_LSB];
assign sel = ~i_port_select_n;
assign req = ~i_access_request_in_n;
assign strobe = strobe_on(mode, i_addr_strobe_in);

// ----------------------------------------
// address capture
// ----------------------------------------
strobe_addr_capture #(
    .BANK_W(BANK_W),
    .ROW_W(ROW_W),
    .COL_W(COL_W)
) u_capture (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_strobe_pin(i_addr_strobe_in),
    .i_latch_en(latch_en),
    .i_bank(i_bank_addr),
    .i_row(i_row_addr),
    .i_col(i_col_addr),
    .o_bank(lat_bank),
    .o_row(lat_row),
    .o_col(lat_col)
);

// ----------------------------------------
// access sequencing
// ----------------------------------------
// mode 1 fast path: row strobe goes out in the same cycle, before the edge
assign start_now = state_ff[0] & strobe_armed_ff & mode & strobe & sel & ~i_event_busy; // RL3 RL6 RL15
// request must be seen asserted first, so a late assert cannot end a fresh access
assign acc_end = state_ff[3] & req_seen_ff & ~req; // RL8
assign enter_acc = nxt_state[3] & ~state_ff[3];

always @* begin
    nxt_state = state_ff;
    nxt_pending = pending_ff;
    nxt_req_seen = req_seen_ff;
    nxt_ras = ras_ff;
    // a released strobe re-arms the port; a held strobe cannot restart it
    nxt_armed = strobe_armed_ff | ~strobe; // RL15
    case (state_ff)
        ST_IDLE: begin
            if (sel & strobe & strobe_armed_ff) begin // RL6 RL15
                nxt_armed = 1'b0;
                nxt_pending = 1'b1; // RL1
                if (!mode) begin
                    nxt_state = ST_PEND;
                end else if (i_event_busy) begin
                    nxt_state = ST_HOLD; // RL4
                end else begin
                    nxt_state = ST_ACC; // RL3
                    nxt_ras = 1'b1;
                end
            end
        end
        ST_PEND: begin
            // select must still be held when the access is launched
            if (sel & ~i_event_busy) begin // RL2 RL6
                nxt_state = ST_ACC;
                nxt_ras = 1'b1;
            end
        end
        ST_HOLD: begin
            if (sel & ~i_event_busy) begin // RL4 RL6
                nxt_state = ST_ACC;
                nxt_ras = 1'b1;
            end
        end
        ST_ACC: begin
            if (acc_end) begin
                nxt_state = ST_IDLE;
                nxt_ras = 1'b0; // RL8
                nxt_pending = 1'b0; // RL15
                nxt_req_seen = 1'b0;
            end
        end
        default: begin
            nxt_state = ST_IDLE;
            nxt_pending = 1'b0;
            nxt_req_seen = 1'b0;
            nxt_ras = 1'b0;
            nxt_armed = 1'b1;
        end
    endcase
    // request may come early in mode 1 or late in mode 0
    if (!state_ff[0] && !acc_end && req) begin // RL7 RL9
        nxt_req_seen = 1'b1;
    end
end

always @(posedge i_mclk) begin
    if (i_rst) begin
        state_ff <= ST_IDLE;
        pending_ff <= 1'b0;
        req_seen_ff <= 1'b0;
        ras_ff <= 1'b0;
        strobe_armed_ff <= 1'b1;
    end else begin
        state_ff <= nxt_state;
        pending_ff <= nxt_pending;
        req_seen_ff <= nxt_req_seen;
        ras_ff <= nxt_ras;
        strobe_armed_ff <= nxt_armed;
    end
end

// ----------------------------------------
// wait states
// ----------------------------------------
// counter runs only in the access state; extend freezes it
wait_state_counter #(
    .WAIT_W(`WAIT_W)
) u_wait (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_load(enter_acc),
    .i_load_val(wait_cfg),
    .i_run(state_ff[3]),
    .i_extend(i_extend_delay_in),
    .o_done(wait_done),
    .o_count(wait_cnt)
);

assign ready = state_ff[3] & wait_done; // RL12 RL13
assign not_ready = ~state_ff[0] & ~ready;

// wait style pulls low while not ready; ack style pulls low once ready
assign o_transfer_ack_out = ack_style ? ~ready : ~not_ready; // RL10 RL11

// ----------------------------------------
// dram strobes and address
// ----------------------------------------
// live bank is used on the fast path since the capture flop lags one edge
assign o_row_strobe_n = ~((ras_ff ? bank_onehot(lat_bank) : {NB{1'b0}}) |
                          (start_now ? bank_onehot(i_bank_addr) : {NB{1'b0}})); // RL14
assign o_mux_addr = lat_row; // RL14
assign o_col_addr = lat_col;
assign o_bank_addr = lat_bank;
assign o_access_active = state_ff[3];

// ----------------------------------------
// register port
// ----------------------------------------
// fields placed by position so the map can move without touching this
always @* begin
    status_word = 32'h00000000;
    status_word[`STAT_PEND_BIT] = pending_ff;
    status_word[`STAT_ACTIVE_BIT] = state_ff[3];
    status_word[`STAT_READY_BIT] = ready;
    status_word[`STAT_HOLD_BIT] = state_ff[2];
    status_word[`STAT_WAIT_LSB +: `WAIT_W] = wait_cnt;
end

always @* begin
    nxt_cfg = cfg_ff;
    nxt_acc_cnt = acc_cnt_ff;
    nxt_rdata = 32'h00000000;
    if (wr_hit(i_reg_wr, i_reg_addr, `OFS_CONFIG)) begin
        nxt_cfg = i_reg_wdata[`CFG_W-1:0];
    end
    if (wr_hit(i_reg_wr, i_reg_addr, `OFS_ACC_COUNT)) begin
        nxt_acc_cnt = `CNT_RST;
    end
    // a completed access in the clearing cycle still counts
    if (acc_end) begin
        nxt_acc_cnt = nxt_acc_cnt + `CNT_ONE;
    end
    if (i_reg_rd) begin
        case (i_reg_addr)
            `OFS_CONFIG: begin
                nxt_rdata = {{(32 - `CFG_W){1'b0}}, cfg_ff};
            end
            `OFS_STATUS: begin
                nxt_rdata = status_word;
            end
            `OFS_ACC_COUNT: begin
                nxt_rdata = {{(32 - `CNT_W){1'b0}}, acc_cnt_ff};
            end
            default: begin
                nxt_rdata = 32'h00000000;
            end
        endcase
    end
end

always @(posedge i_mclk) begin
    if (i_rst) begin
        cfg_ff <= `CFG_RST;
        acc_cnt_ff <= `CNT_RST;
        rdata_ff <= 32'h00000000;
    end else begin
        cfg_ff <= nxt_cfg;
        acc_cnt_ff <= nxt_acc_cnt;
        rdata_ff <= nxt_rdata;
    end
end

assign o_reg_rdata = rdata_ff;

endmodule

// ===== port_a_chk_asserts.sv
// assertions for the port a access front end
`timescale 1ns/100ps
`include "dram_port_a_map.vh"
module port_a_chk #(
    parameter BANK_W = 2,
    parameter ROW_W = 11,
    parameter COL_W = 11
) (
    // clock, reset, register writes
    input wire i_mclk,
    input wire i_rst,
    input wire [`REG_ADDR_W-1:0] i_reg_addr,
    input wire [31:0] i_reg_wdata,
    input wire i_reg_wr,
    // access port
    input wire i_addr_strobe_in,
    input wire i_port_select_n,
    input wire i_access_request_in_n,
    input wire i_extend_delay_in,
    input wire i_event_busy,
    input wire [BANK_W-1:0] i_bank_addr,
    input wire [ROW_W-1:0] i_row_addr,
    // outputs
    input wire [(1<<BANK_W)-1:0] o_row_strobe_n,
    input wire [ROW_W-1:0] o_mux_addr,
    input wire o_transfer_ack_out,
    input wire o_access_active
);
    reg [7:0] cfg_ff = 8'h14;
    reg [4:0] cnt_ff = 5'h00;
    wire m1 = cfg_ff[`CFG_MODE_BIT];
    wire sty = cfg_ff[`CFG_ACK_STYLE_BIT];
    wire [4:0] n_wait = {1'b0, cfg_ff[`CFG_WAIT_MSB:`CFG_WAIT_LSB]};
    // shadow of config so checks follow the programmed mode
    always @(posedge i_mclk) begin
        if (i_rst) begin
            cfg_ff <= `CFG_RST;
        end else if (i_reg_wr && i_reg_addr == `OFS_CONFIG) begin
            cfg_ff <= i_reg_wdata[7:0];
        end
    end
    // unextended edges inside an access, saturating
    always @(posedge i_mclk) begin
        if (i_rst || !o_access_active) begin
            cnt_ff <= 5'h00;
        end else if (!i_extend_delay_in && cnt_ff != 5'h1f) begin
            cnt_ff <= cnt_ff + 5'h01;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    sequence s_m0_latch;
        $rose(i_addr_strobe_in) && !m1 && !i_port_select_n && !o_access_active;
    endsequence
    sequence s_m1_held;
        $fell(i_addr_strobe_in) && m1 && !i_port_select_n && i_event_busy && !o_access_active
        ##1 (!i_port_select_n && i_event_busy) [*2] ##1 (!i_port_select_n && !i_event_busy);
    endsequence
    a_select_gates: assert property ($rose(o_access_active) |-> !$past(i_port_select_n))
        else $error("access began while deselected");
    a_m0_entry: assert property (s_m0_latch ##1 (!i_port_select_n && !i_event_busy) |=> o_access_active)
        else $error("latched access did not start");
    a_m0_pend_wait: assert property ($rose(i_addr_strobe_in) && !m1 && !sty && !i_port_select_n
        && !o_access_active |=> !o_transfer_ack_out)
        else $error("no wait while pending");
    a_m1_fast_ras: assert property ($fell(i_addr_strobe_in) && m1 && !i_port_select_n && !i_event_busy
        && !o_access_active |-> !o_row_strobe_n[i_bank_addr] ##1 o_access_active)
        else $error("row strobe not immediate");
    a_m1_after_busy: assert property (s_m1_held |=> o_access_active)
        else $error("access late after busy");
    a_req_ends: assert property ($rose(i_access_request_in_n) && o_access_active
        |=> !o_access_active && &o_row_strobe_n)
        else $error("access did not end");
    a_wait_count: assert property (o_access_active |-> o_transfer_ack_out == (sty ^ (cnt_ff > n_wait)))
        else $error("ack level wrong for wait count");
    a_addr_latch: assert property ($fell(i_addr_strobe_in) && cfg_ff[`CFG_LATCH_BIT]
        |=> o_mux_addr == $past(i_row_addr))
        else $error("row address not captured");
endmodule

// ===== port_a_requester.sv
// requester model driving strobe, select, request and extend
`timescale 1ns/100ps
module port_a_requester (
    // clock and device answer
    input wire i_mclk,
    input wire i_ack,
    // request side
    output reg o_strobe = 1'b0,
    output reg o_sel_n = 1'b1,
    output reg o_req_n = 1'b1,
    output reg o_ext = 1'b0,
    output reg [23:0] o_adr = 24'h000000
);
    // one access; ok stays low if ready never shows
    task go(input m, input sty, input [3:0] e, input [23:0] adr, output ok);
        integer i;
        begin
            ok = 1'b0;
            @(posedge i_mclk);
            o_strobe <= m;
            @(posedge i_mclk);
            o_strobe <= ~m;
            o_sel_n <= 1'b0;
            o_adr <= adr;
            o_req_n <= ~m;
            @(posedge i_mclk);
            if (!m) begin
                o_strobe <= 1'b0;
                o_req_n <= 1'b0;
                @(posedge i_mclk);
            end
            for (i = 0; i < 100 && !ok; i = i + 1) begin
                o_ext <= (i < e);
                o_strobe <= m;
                // released address lines no longer hold the value
                if (i == 1) begin
                    o_adr <= ~adr;
                end
                @(posedge i_mclk);
                ok = i_ack ^ sty;
            end
            o_req_n <= 1'b1;
            o_ext <= 1'b0;
            @(posedge i_mclk);
            o_sel_n <= 1'b1;
        end
    endtask
endmodule

// ===== tb.sv
// self-checking bench for the port a access front end
`timescale 1ns/100ps
`include "dram_port_a_map.vh"
module tb;
    reg i_mclk = 1'b0;
    reg i_rst = 1'b1;
    reg [7:0] i_reg_addr = 8'h00;
    reg [31:0] i_reg_wdata = 32'h0;
    reg i_reg_wr = 1'b0;
    reg i_reg_rd = 1'b0;
    reg i_event_busy = 1'b0;
    reg rd_d = 1'b0;
    reg sty = 1'b0;
    reg seen = 1'b0;
    reg ok;
    reg [3:0] nw;
    reg [23:0] adr;
    reg [31:0] exp_q[$];
    reg [31:0] rd_q[$];
    integer seed = 40;
    integer fail_count = 0;
    integer n_tests = 0;
    integer cnt = 0;
    integer i;
    wire strobe, sel_n, req_n, ext, ack, active;
    wire [23:0] a;
    wire [31:0] rdata;
    wire [10:0] row;
    wire [10:0] col;
    wire [1:0] bank;
    dram_port_a_access_handshake dut (
        .i_mclk(i_mclk), .i_rst(i_rst),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(rdata),
        .i_addr_strobe_in(strobe), .i_port_select_n(sel_n),
        .i_access_request_in_n(req_n), .i_extend_delay_in(ext),
        .i_event_busy(i_event_busy), .i_bank_addr(a[23:22]),
        .i_row_addr(a[21:11]), .i_col_addr(a[10:0]),
        .o_row_strobe_n(), .o_mux_addr(row), .o_col_addr(col), .o_bank_addr(bank),
        .o_transfer_ack_out(ack), .o_access_active(active)
    );
    port_a_requester rq (
        .i_mclk(i_mclk), .i_ack(ack), .o_strobe(strobe), .o_sel_n(sel_n),
        .o_req_n(req_n), .o_ext(ext), .o_adr(a)
    );
    initial begin
        forever #2.5 i_mclk = ~i_mclk;
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wrap_up;
        begin
            $display("checks=%0d errors=%0d", n_tests, fail_count);
            if (fail_count == 0 && n_tests > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask
    task wr(input [7:0] ad, input [31:0] d);
        begin
            i_reg_addr <= ad;
            i_reg_wdata <= d;
            i_reg_wr <= 1'b1;
            @(posedge i_mclk);
            i_reg_wr <= 1'b0;
            // idle edge so back-to-back calls never drive the strobe twice at once
            @(posedge i_mclk);
        end
    endtask
    task rd(input [7:0] ad, input [31:0] exp);
        begin
            rd_q.push_back(exp);
            i_reg_addr <= ad;
            i_reg_rd <= 1'b1;
            @(posedge i_mclk);
            i_reg_rd <= 1'b0;
            @(posedge i_mclk);
        end
    endtask
    // wait count is random; latency expected is count plus extends plus two
    task acc(input m, input s, input [3:0] e);
        begin
            sty = s;
            nw = $random(seed);
            adr = $random(seed);
            wr(`OFS_CONFIG, {24'h0, nw, 2'b01, s, m});
            exp_q.push_back(nw + e + 2);
            rq.go(m, s, e, adr, ok);
            if (!ok) begin
                fail_count = fail_count + 1;
                wrap_up;
            end
            chk(row, adr[21:11]);
            chk(col, adr[10:0]);
            chk(bank, adr[23:22]);
        end
    endtask
    // register read data stands one cycle after the strobe
    always @(posedge i_mclk) begin
        if (rd_d) begin
            chk(rdata, rd_q.pop_front());
        end
        rd_d <= i_reg_rd;
    end
    // ready latency counted from the access entry edge
    always @(posedge i_mclk) begin
        if (!active) begin
            cnt = 0;
            seen = 1'b0;
        end else begin
            cnt = cnt + 1;
            if (!seen && (ack ^ sty)) begin
                seen = 1'b1;
                chk(cnt, exp_q.pop_front());
            end
        end
    end
    initial begin
        repeat (8) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        rd(`OFS_CONFIG, 32'h14);
        rd(8'h0c, 32'h0);
        for (i = 0; i < 8; i = i + 1) begin
            acc(i[0], i[1], $random(seed));
        end
        i_event_busy <= 1'b1;
        fork
            acc(1'b1, 1'b0, 4'h0);
            begin
                repeat (7) @(posedge i_mclk);
                i_event_busy <= 1'b0;
            end
        join
        rd(`OFS_ACC_COUNT, 32'h9);
        wr(`OFS_ACC_COUNT, 32'h0);
        rd(`OFS_ACC_COUNT, 32'h0);
        rd(`OFS_STATUS, 32'h0);
        repeat (2) @(posedge i_mclk);
        chk(exp_q.size(), 0);
        wrap_up;
    end
endmodule
bind dram_port_a_access_handshake port_a_chk #(.BANK_W(BANK_W), .ROW_W(ROW_W), .COL_W(COL_W)) u_chk (.*);
